/* sfru_pkg.sv */
// Shared constants, field layouts and carrier types of the frame restructure unit.
// Assumes a 32-bit classic Wishbone register bus and a 64-entry local register stack.
package sfru_pkg;

  localparam int ADDR_W = 5;
  localparam int FP_W   = 7;
  localparam int FL_W   = 4;
  localparam int CODE_W = 4;
  localparam int DIFF_W = 7;
  localparam int LREG_W = 6;
  localparam int EVT_W  = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_FRAME   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_SP      = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_UB      = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_INFO    = 5'h18;

  // Field positions
  localparam int POS_FL    = 8;
  localparam int POS_CMODE = 4;
  localparam int POS_TMP   = 8;
  localparam int POS_BUSY  = 9;
  localparam int EVT_DONE  = 0;
  localparam int EVT_ERR   = 1;

  // Reset values
  localparam logic [FP_W-1:0] RST_FP = 7'h00;
  localparam logic [FL_W-1:0] RST_FL = 4'h0;
  localparam logic [31:0]     RST_SP = 32'h0000_0000;
  localparam logic [31:0]     RST_UB = 32'h0000_0000;

  // Stack arithmetic, carried in 8 bits so 64 does not wrap
  localparam logic [7:0]  LOCAL_REGS   = 8'h40;
  localparam logic [7:0]  FL_ZERO_AS   = 8'h10;
  localparam logic [7:0]  RES_CALL     = 8'h06;
  localparam logic [7:0]  RES_EXC      = 8'h02;
  localparam logic [7:0]  RES_SPARE    = 8'h02;
  localparam logic [7:0]  RESERVE_REGS = RES_CALL + RES_EXC + RES_SPARE;
  localparam logic [31:0] SP_STEP      = 32'h0000_0004;
  localparam logic [DIFF_W-1:0] DIFF_LAST = 7'h7F;

  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] src_code;
    logic [CODE_W-1:0] dst_code;
  } sfru_frame_op_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } sfru_mem_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_CALC  = 4'h2,
    ST_FETCH = 4'h4,
    ST_WRITE = 4'h8
  } sfru_state_t;

  function automatic logic [31:0] sfru_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

endpackage

/* sfru_frame_calc.sv */
// Free-register difference of the current frame against the register stack.
// Purely combinational; the caller samples the result in its own state.
`timescale 1ns/1ps
module sfru_frame_calc
  import sfru_pkg::*;
(
  input  wire logic [DIFF_W-1:0] sp_bits_i,
  input  wire logic [FP_W-1:0]   fp_i,
  input  wire logic [FL_W-1:0]   fl_i,
  output logic      [DIFF_W-1:0] diff_o,
  output logic                   neg_o
);
  logic [7:0] fl_eff;
  logic [7:0] sum;

  always_comb begin
    fl_eff = (fl_i == 4'h0) ? FL_ZERO_AS : {4'h0, fl_i};
    sum    = {1'b0, sp_bits_i} + LOCAL_REGS - RESERVE_REGS - ({1'b0, fp_i} + fl_eff);
    diff_o = sum[DIFF_W-1:0];
    neg_o  = sum[DIFF_W-1];
  end
endmodule // sfru_frame_calc

/* sfru_irq_ctrl.sv */
// Sticky event bits with write-one-to-clear, a mask and one level interrupt.
// Assumes write strobes are single-cycle pulses from the bus slave.
`timescale 1ns/1ps
module sfru_irq_ctrl #(
  parameter int W = 2
) (
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] evt_i,
  input  wire logic         clr_we_i,
  input  wire logic         mask_we_i,
  input  wire logic [W-1:0] wdata_i,
  output logic      [W-1:0] status_o,
  output logic      [W-1:0] mask_o,
  output logic              irq_o
);
  logic [W-1:0] st_d;
  logic [W-1:0] msk_d;

  // A new event wins over a clear in the same cycle
  assign st_d  = (clr_we_i ? (status_o & ~wdata_i) : status_o) | evt_i;
  assign msk_d = mask_we_i ? wdata_i : mask_o;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      status_o <= '0;
      mask_o   <= '0;
      irq_o    <= 1'b0;
    end else begin
      status_o <= st_d;
      mask_o   <= msk_d;
      irq_o    <= |(st_d & msk_d);
    end
  end
endmodule // sfru_irq_ctrl

/* sfru_top.sv */
// Frame restructure execution unit with Wishbone register access.
// Assumes the local register file returns lreg_data_i for lreg_addr_o in the same cycle that
// the address changes, and that the data memory answers each write with one mem_ack_i pulse.
`timescale 1ns/1ps
module sfru_top
  import sfru_pkg::*;
(
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [ADDR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire sfru_frame_op_t       frame_op_i,
  output logic                      issue_stall_o,
  output logic                      frame_done_o,
  output logic                      frame_trap_o,
  output logic      [LREG_W-1:0]    lreg_addr_o,
  input  wire logic [31:0]          lreg_data_i,
  output sfru_mem_wr_t              mem_wr_o,
  input  wire logic                 mem_ack_i,
  output logic                      irq_o
);

  sfru_state_t       state_q;
  logic [FP_W-1:0]   fp_q;
  logic [FL_W-1:0]   fl_q;
  logic [3:0]        cond_q;
  logic              cmode_q;
  logic [31:0]       sp_q;
  logic [31:0]       ub_q;
  logic              tmp_q;
  logic [DIFF_W-1:0] cnt_q;
  logic [DIFF_W-1:0] diff;
  logic              diff_neg;
  logic              take;
  logic              busy;
  logic              acked;
  logic              last;
  logic              fin;
  logic              acc;
  logic              wr;
  logic [31:0]       sp_nx;
  logic [EVT_W-1:0]  evt;
  logic [EVT_W-1:0]  irq_st;
  logic [EVT_W-1:0]  irq_msk;

  assign busy  = (state_q != ST_IDLE);
  assign take  = (state_q == ST_IDLE) && frame_op_i.valid;
  assign acked = (state_q == ST_WRITE) && mem_ack_i;
  assign last  = (cnt_q == DIFF_LAST);
  assign fin   = ((state_q == ST_CALC) && !diff_neg) || (acked && last);
  assign acc   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr    = acc && wb_we_i;
  assign sp_nx = sp_q + SP_STEP;
  assign evt   = {fin && (state_q == ST_WRITE) && tmp_q, fin};

  sfru_frame_calc u_calc (
    .sp_bits_i (sp_q[8:2]),
    .fp_i      (fp_q),
    .fl_i      (fl_q),
    .diff_o    (diff),
    .neg_o     (diff_neg)
  );

  sfru_irq_ctrl #(
    .W (EVT_W)
  ) u_irq (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .evt_i     (evt),
    .clr_we_i  (wr && wb_sel_i[0] && (wb_adr_i == OFS_IRQ_ST)),
    .mask_we_i (wr && wb_sel_i[0] && (wb_adr_i == OFS_IRQ_MSK)),
    .wdata_i   (wb_dat_i[EVT_W-1:0]),
    .status_o  (irq_st),
    .mask_o    (irq_msk),
    .irq_o     (irq_o)
  );

  // Sequencer
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:  if (take) state_q <= ST_CALC;
        ST_CALC:  state_q <= diff_neg ? ST_FETCH : ST_IDLE;
        ST_FETCH: state_q <= ST_WRITE;
        ST_WRITE: if (mem_ack_i) state_q <= last ? ST_IDLE : ST_FETCH;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Frame pointer and length
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fp_q <= RST_FP;
      fl_q <= RST_FL;
    end else if (take) begin
      fp_q <= fp_q - {3'h0, frame_op_i.src_code};
      fl_q <= frame_op_i.dst_code;
    end else if (!busy && wr && (wb_adr_i == OFS_FRAME)) begin
      if (wb_sel_i[0]) fp_q <= wb_dat_i[FP_W-1:0];
      if (wb_sel_i[1]) fl_q <= wb_dat_i[POS_FL +: FL_W];
    end
  end

  // Status word: only the cache-mode flag is touched by the frame operation
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cond_q  <= 4'h0;
      cmode_q <= 1'b0;
    end else if (take) begin
      cmode_q <= 1'b0;
    end else if (!busy && wr && wb_sel_i[0] && (wb_adr_i == OFS_STATUS)) begin
      cond_q  <= wb_dat_i[3:0];
      cmode_q <= wb_dat_i[POS_CMODE];
    end
  end

  // Stack pointer and bound
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sp_q <= RST_SP;
    end else if (acked) begin
      sp_q <= sp_nx;
    end else if (!busy && wr && (wb_adr_i == OFS_SP)) begin
      sp_q <= sfru_merge(sp_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ub_q <= RST_UB;
    end else if (wr && (wb_adr_i == OFS_UB)) begin
      ub_q <= sfru_merge(ub_q, wb_dat_i, wb_sel_i);
    end
  end

  // Bound flag taken once before the spill; negated count of outstanding words, stepped up on each acknowledge, past 7F to 00
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tmp_q <= 1'b0;
      cnt_q <= '0;
    end else if ((state_q == ST_CALC) && diff_neg) begin
      tmp_q <= (sp_q >= ub_q);
      cnt_q <= diff;
    end else if (acked) begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  // Spill write port
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      lreg_addr_o <= '0;
      mem_wr_o    <= '0;
    end else begin
      if ((state_q == ST_CALC) && diff_neg) begin
        lreg_addr_o <= sp_q[7:2];
      end else if (acked) begin
        lreg_addr_o <= sp_nx[7:2];
      end
      if (state_q == ST_FETCH) begin
        mem_wr_o.valid <= 1'b1;
        mem_wr_o.addr  <= sp_q;
        mem_wr_o.data  <= lreg_data_i;
      end else if (acked) begin
        mem_wr_o.valid <= 1'b0;
      end
    end
  end

  // Completion, trap and issue stall
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      frame_done_o  <= 1'b0;
      frame_trap_o  <= 1'b0;
      issue_stall_o <= 1'b0;
    end else begin
      frame_done_o  <= fin;
      frame_trap_o  <= acked && last && tmp_q;
      issue_stall_o <= take || (busy && !fin);
    end
  end

  // Wishbone slave: one wait state, zero on unmapped reads
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      if (acc) begin
        unique case (wb_adr_i)
          OFS_FRAME:   wb_dat_o <= {20'h0_0000, fl_q, 1'b0, fp_q};
          OFS_STATUS:  wb_dat_o <= {27'h000_0000, cmode_q, cond_q};
          OFS_SP:      wb_dat_o <= sp_q;
          OFS_UB:      wb_dat_o <= ub_q;
          OFS_IRQ_ST:  wb_dat_o <= {30'h0000_0000, irq_st};
          OFS_IRQ_MSK: wb_dat_o <= {30'h0000_0000, irq_msk};
          OFS_INFO:    wb_dat_o <= {22'h00_0000, busy, tmp_q, 1'b0, cnt_q};
          default:     wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence op_taken_s;
    (state_q == ST_IDLE) && frame_op_i.valid;
  endsequence

  sequence spill_last_s;
    (state_q == ST_WRITE) && mem_ack_i && (cnt_q == 7'h7F);
  endsequence

  fp_sub_a:
    assert property (op_taken_s |=> fp_q == 7'($past(fp_q) - {3'h0, $past(frame_op_i.src_code)}))
    else $error("frame pointer not reduced by source code");

  fl_zero_a:
    assert property (((state_q == ST_CALC) && (fl_q == 4'h0) && (fp_q == 7'h00) && (sp_q[8:2] == 7'h00))
                     |-> (diff == 7'h26))
    else $error("zero frame length not taken as sixteen");

  fl_load_a:
    assert property (op_taken_s |=> fl_q == $past(frame_op_i.dst_code))
    else $error("frame length not loaded");

  mode_clr_a:
    assert property (op_taken_s |=> !cmode_q)
    else $error("cache mode flag not cleared");

  diff_sign_a:
    assert property (((state_q == ST_CALC) && (fl_q == 4'h6) && (fp_q == 7'h30) && (sp_q[8:2] == 7'h00))
                     |-> !diff_neg && (diff == 7'h00))
    else $error("difference formula wrong");

  no_spill_a:
    assert property (((state_q == ST_CALC) && !diff_neg) |=> (state_q == ST_IDLE) && frame_done_o
                     && !mem_wr_o.valid)
    else $error("non-negative difference did not finish at once");

  tmp_flag_a:
    assert property (((state_q == ST_CALC) && diff_neg) |=> tmp_q == ($past(sp_q) >= $past(ub_q)))
    else $error("bound flag wrong");

  spill_addr_a:
    assert property ($rose(mem_wr_o.valid) |-> (mem_wr_o.addr == sp_q) && (lreg_addr_o == sp_q[7:2]))
    else $error("spill address or register wrong");

  sp_step_a:
    assert property (((state_q == ST_WRITE) && mem_ack_i) |=> (sp_q == $past(sp_q) + 32'h4)
                     && (cnt_q == 7'($past(cnt_q) + 7'h01)))
    else $error("stack pointer or count did not step");

  trap_after_a:
    assert property (spill_last_s ##0 tmp_q |=> frame_trap_o && (state_q == ST_IDLE))
    else $error("frame error trap missing after spill");

  trap_only_a:
    assert property (frame_trap_o |-> $past((state_q == ST_WRITE) && mem_ack_i && (cnt_q == 7'h7F) && tmp_q))
    else $error("frame error trap at wrong time");

  flags_keep_a:
    assert property (busy |=> $stable(cond_q))
    else $error("condition flags changed");

  no_stop_a:
    assert property (((state_q == ST_WRITE) && mem_ack_i && (cnt_q != 7'h7F)) |=> (state_q == ST_FETCH)
                     ##1 mem_wr_o.valid)
    else $error("spill stopped early");

  stall_a:
    assert property ((mem_wr_o.valid && !mem_ack_i) |=> mem_wr_o.valid && $stable(sp_q) && issue_stall_o)
    else $error("write not held until accepted");

  done_pulse_a:
    assert property (frame_done_o |=> !frame_done_o)
    else $error("done held longer than one cycle");

  stall_idle_a:
    assert property (((state_q == ST_IDLE) && !take) |=> !issue_stall_o)
    else $error("issue stalled while idle");

  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held too long");

endmodule // sfru_top

/* sfru_mem_model.sv */
// Data memory holding the spilled part of the stack; logs every accepted write.
// Assumes one outstanding write, held by the unit until acknowledged.
`timescale 1ns/1ps
module sfru_mem_model
  import sfru_pkg::*;
(
  input  wire logic         clk_sys_i,
  input  wire logic         sys_rst_i,
  input  wire sfru_mem_wr_t mem_wr_i,
  output logic              mem_ack_o
);
  logic [31:0] log_addr [0:31];
  logic [31:0] log_data [0:31];
  int          n_wr;
  int          wait_cnt;
  // Words at odd word addresses are answered slowly, the rest at once
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mem_ack_o <= 1'b0;
      wait_cnt  <= 0;
    end else if (mem_wr_i.valid && !mem_ack_o) begin
      if (wait_cnt >= (mem_wr_i.addr[2] ? 3 : 0)) begin
        mem_ack_o <= 1'b1;
        wait_cnt  <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end else begin
      mem_ack_o <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      n_wr <= 0;
    end else if (mem_ack_o && mem_wr_i.valid) begin
      log_addr[n_wr] <= mem_wr_i.addr;
      log_data[n_wr] <= mem_wr_i.data;
      n_wr           <= n_wr + 1;
    end
  end
endmodule // sfru_mem_model

/* tb_top.sv */
// Self-checking bench of the frame restructure unit.
// Assumes the local register file reads combinationally; memory is a model.
`timescale 1ns/1ps
module tb_top
  import sfru_pkg::*;
;
  logic           clk_sys_i = 1'b0;
  logic           sys_rst_i = 1'b1;
  logic           wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [3:0]     wb_sel_i = 4'h0;
  logic [31:0]    wb_dat_i = 32'h0;
  logic [31:0]    wb_dat_o;
  logic           wb_ack_o, issue_stall_o, frame_done_o, frame_trap_o, mem_ack_i, irq_o;
  sfru_frame_op_t frame_op_i = '0;
  logic [LREG_W-1:0] lreg_addr_o;
  logic [31:0]    lreg_data_i;
  sfru_mem_wr_t   mem_wr_o;
  int             num_errors = 0;
  int             check_count = 0;
  int             cycles = 0;
  logic [31:0]    rd;
  logic           trap_seen;

  assign lreg_data_i = 32'hA5A5_0000 | {26'h0, lreg_addr_o};

  sfru_top uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .frame_op_i(frame_op_i), .issue_stall_o(issue_stall_o), .frame_done_o(frame_done_o),
    .frame_trap_o(frame_trap_o), .lreg_addr_o(lreg_addr_o), .lreg_data_i(lreg_data_i), .mem_wr_o(mem_wr_o),
    .mem_ack_i(mem_ack_i), .irq_o(irq_o));
  sfru_mem_model mem (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .mem_wr_i(mem_wr_o), .mem_ack_o(mem_ack_i));

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [ADDR_W-1:0] adr, input logic [31:0] dat);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    for (n = 0; n < 50; n++) begin
      @(negedge clk_sys_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Issues one frame op and waits for completion, noting any trap pulse
  task automatic frame(input logic [3:0] src, input logic [3:0] dst);
    int n;
    frame_op_i <= '{1'b1, src, dst};
    @(posedge clk_sys_i);
    frame_op_i <= '0;
    trap_seen = 1'b0;
    for (n = 0; n < 300; n++) begin
      @(negedge clk_sys_i);
      if (n == 0) check("stall", 32'h1, {31'h0, issue_stall_o === 1'b1});
      if (frame_trap_o === 1'b1) trap_seen = 1'b1;
      if (frame_done_o === 1'b1) break;
    end
    check("done", 32'h1, {31'h0, frame_done_o === 1'b1});
    check("stall off", 32'h0, {31'h0, issue_stall_o !== 1'b0});
    @(posedge clk_sys_i);
  endtask

  task automatic check_spill(input int first, input int cnt, input logic [31:0] sp0);
    for (int i = 0; i < cnt; i++) begin
      check("wr addr", sp0 + 32'(4 * i), mem.log_addr[first + i]);
      check("wr data", 32'hA5A5_0000 | (((sp0 >> 2) + 32'(i)) & 32'h0000_003F), mem.log_data[first + i]);
    end
    check("wr count", 32'(first + cnt), 32'(mem.n_wr));
  endtask

  task automatic test_reset();
    wb(1'b0, OFS_FRAME, 32'h0);
    check("frame rst", 32'h0, rd);
    wb(1'b0, OFS_SP, 32'h0);
    check("sp rst", 32'h0, rd);
    wb(1'b0, 5'h1C, 32'h0);
    check("unmapped", 32'h0, rd);
  endtask

  task automatic test_no_spill();
    wb(1'b1, OFS_STATUS, 32'h0000_001F);
    wb(1'b1, OFS_FRAME, 32'h0000_000A);
    frame(4'h2, 4'h4);
    wb(1'b0, OFS_FRAME, 32'h0);
    check("frame", 32'h0000_0408, rd);
    wb(1'b0, OFS_STATUS, 32'h0);
    check("status", 32'h0000_000F, rd);
    check("no write", 32'h0, 32'(mem.n_wr));
  endtask

  task automatic test_spill_trap();
    wb(1'b1, OFS_FRAME, 32'h0000_0028);
    frame(4'h0, 4'h0);
    check("trap", 32'h1, {31'h0, trap_seen});
    check_spill(0, 2, 32'h0);
    wb(1'b0, OFS_SP, 32'h0);
    check("sp", 32'h0000_0008, rd);
  endtask

  task automatic test_spill_busy();
    wb(1'b1, OFS_UB, 32'h0000_1000);
    wb(1'b1, OFS_FRAME, 32'h0000_003C);
    fork
      frame(4'h0, 4'h3);
      begin
        repeat (4) @(posedge clk_sys_i);
        wb(1'b1, OFS_SP, 32'hFFFF_0000);
      end
    join
    check("no trap", 32'h0, {31'h0, trap_seen});
    check_spill(2, 7, 32'h8);
    wb(1'b0, OFS_SP, 32'h0);
    check("sp busy", 32'h0000_0024, rd);
  endtask

  task automatic test_irq();
    wb(1'b0, OFS_IRQ_ST, 32'h0);
    check("irq st", 32'h3, rd);
    check("irq off", 32'h0, {31'h0, irq_o});
    wb(1'b1, OFS_IRQ_MSK, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    check("irq on", 32'h1, {31'h0, irq_o});
    wb(1'b1, OFS_IRQ_ST, 32'h2);
    repeat (2) @(posedge clk_sys_i);
    check("irq clr", 32'h0, {31'h0, irq_o});
    wb(1'b0, OFS_IRQ_ST, 32'h0);
    check("irq left", 32'h1, rd);
  endtask

  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    test_reset();
    test_no_spill();
    test_spill_trap();
    test_spill_busy();
    test_irq();
    complete_run();
  end
endmodule // tb_top
